/* File: hdl/csf_pkg.sv */
// package of offsets, field positions and reset values for the codec status flag registers
package csf_pkg;
	localparam int CSF_AW = 8;
	localparam int CSF_DW = 8;
	typedef logic [CSF_AW-1:0] csf_addr_t;
	typedef logic [CSF_DW-1:0] csf_data_t;
	// status register offsets (page 0)
	localparam csf_addr_t CSF_OFF_PWR = 8'h5e;
	localparam csf_addr_t CSF_OFF_SHORT = 8'h5f;
	localparam csf_addr_t CSF_OFF_LATCHED = 8'h60;
	localparam csf_addr_t CSF_OFF_LIVE = 8'h61;
	// register whose read clears the live button bit
	localparam csf_addr_t CSF_OFF_BTN_CLR = 8'h0e;
	// interrupt block offsets
	localparam csf_addr_t CSF_OFF_IRQ_STAT = 8'h70;
	localparam csf_addr_t CSF_OFF_IRQ_EN = 8'h71;
	localparam csf_addr_t CSF_OFF_IRQ_CLR = 8'h72;
	localparam csf_data_t CSF_RST = 8'h00;
	// power status fields
	localparam int CSF_PWR_LDAC = 7;
	localparam int CSF_PWR_RDAC = 6;
	localparam int CSF_PWR_MONO = 5;
	localparam int CSF_PWR_LLINE = 4;
	localparam int CSF_PWR_RLINE = 3;
	localparam int CSF_PWR_LHP = 2;
	localparam int CSF_PWR_RHP = 1;
	// short/power register fields
	localparam int CSF_SC_HI = 7;
	localparam int CSF_SC_LO = 4;
	localparam int CSF_SC_LCOM_PWR = 3;
	localparam int CSF_SC_RCOM_PWR = 2;
	// flag register fields
	localparam int CSF_FL_BTN = 3;
	localparam int CSF_FL_HSET = 2;
	localparam int CSF_FL_LNOISE = 1;
	localparam int CSF_FL_RNOISE = 0;
	// interrupt status bits
	localparam int CSF_IRQ_SHORT = 0;
	localparam int CSF_IRQ_BTN = 1;
	localparam int CSF_IRQ_HSET = 2;
	localparam int CSF_IRQ_NOISE = 3;
	localparam int CSF_IRQ_W = 4;
endpackage : csf_pkg

/* File: hdl/csf_status_regs.sv */
// read-only power, short-circuit and event flag registers with interrupt status

// Notes on behaviour
// (RULE1) four read-only status registers, reset zero
// (RULE2) bits 7,6 show converter power-up done
// (RULE3) bits 5,4,3 show line driver power
// (RULE4) bits 2,1 show headphone driver power
// (RULE5) software leaves power bit 0; reads zero
// (RULE6) short register bits 7..4 show shorts
// (RULE7) short register bits 3,2 common power
// (RULE8) short register bits 1..0 reserved zero
// (RULE9) latched register holds short events
// (RULE10) latched button press and headset change
// (RULE11) bits 1,0 show noise-gate below threshold
// (RULE12) live register follows short detectors
// (RULE13) live bit 2 is headset present level
// (RULE14) live button bit cleared by register 14 read
// (RULE15) reading latched register clears its bits
module csf_status_regs (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// register port
	input wire csf_pkg::csf_addr_t addr,
	input wire csf_pkg::csf_data_t wdata,
	input wire logic wr,
	input wire logic rd,
	output csf_pkg::csf_data_t rdata,
	// converter and driver power-up status
	input wire logic left_dac_powered,
	input wire logic right_dac_powered,
	input wire logic mono_line_driver_powered,
	input wire logic left_line_driver_powered,
	input wire logic right_line_driver_powered,
	input wire logic left_headphone_driver_powered,
	input wire logic right_headphone_driver_powered,
	input wire logic left_common_driver_powered,
	input wire logic right_common_driver_powered,
	// short detectors: left hp, right hp, left com, right com (bit 3..0)
	input wire logic [3:0] driver_short,
	// headset and gain-control detectors
	input wire logic button_press,
	input wire logic headset_present,
	input wire logic left_noise_low,
	input wire logic right_noise_low,
	// interrupt
	output logic irq
);
	import csf_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// three-stage synchronisers for detector levels
	localparam int NS = 17;
	// positions of each detector within the synchroniser word
	localparam int IX_LDAC = 16;
	localparam int IX_RDAC = 15;
	localparam int IX_MONO = 14;
	localparam int IX_LLINE = 13;
	localparam int IX_RLINE = 12;
	localparam int IX_LHP = 11;
	localparam int IX_RHP = 10;
	localparam int IX_LCOM = 9;
	localparam int IX_RCOM = 8;
	localparam int IX_SC_HI = 7;
	localparam int IX_SC_LO = 4;
	localparam int IX_BTN = 3;
	localparam int IX_HSET = 2;
	localparam int IX_LNOISE = 1;
	localparam int IX_RNOISE = 0;
	logic [NS-1:0] raw;
	logic [NS-1:0] s1_reg;
	logic [NS-1:0] s2_reg;
	logic [NS-1:0] s3_reg;
	logic [NS-1:0] q_reg;

	// gather the detector pins into one word
	always_comb begin
		raw = '0;
		raw[IX_LDAC] = left_dac_powered;
		raw[IX_RDAC] = right_dac_powered;
		raw[IX_MONO] = mono_line_driver_powered;
		raw[IX_LLINE] = left_line_driver_powered;
		raw[IX_RLINE] = right_line_driver_powered;
		raw[IX_LHP] = left_headphone_driver_powered;
		raw[IX_RHP] = right_headphone_driver_powered;
		raw[IX_LCOM] = left_common_driver_powered;
		raw[IX_RCOM] = right_common_driver_powered;
		raw[IX_SC_HI:IX_SC_LO] = driver_short;
		raw[IX_BTN] = button_press;
		raw[IX_HSET] = headset_present;
		raw[IX_LNOISE] = left_noise_low;
		raw[IX_RNOISE] = right_noise_low;
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			s1_reg <= '0;
			s2_reg <= '0;
			s3_reg <= '0;
		end else begin
			s1_reg <= raw;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
		end
	end

	// a change counts once stages two and three agree
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			q_reg <= '0;
		end else begin
			for (int i = 0; i < NS; i++) begin
				if (s2_reg[i] == s3_reg[i]) begin
					q_reg[i] <= s3_reg[i];
				end
			end
		end
	end

	logic [3:0] sc_now;
	logic btn_now;
	logic hset_now;
	logic [1:0] noise_now;
	logic btn_prev_reg;
	logic hset_prev_reg;
	logic [3:0] sc_prev_reg;
	logic btn_rise;
	logic hset_chg;
	logic [3:0] sc_rise;
	assign sc_now = q_reg[IX_SC_HI:IX_SC_LO];
	assign btn_now = q_reg[IX_BTN];
	assign hset_now = q_reg[IX_HSET];
	assign noise_now = q_reg[IX_LNOISE:IX_RNOISE];

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			btn_prev_reg <= 1'b0;
			hset_prev_reg <= 1'b0;
			sc_prev_reg <= 4'h0;
		end else begin
			btn_prev_reg <= btn_now;
			hset_prev_reg <= hset_now;
			sc_prev_reg <= sc_now;
		end
	end
	assign btn_rise = btn_now & ~btn_prev_reg;
	assign hset_chg = hset_now ^ hset_prev_reg;
	assign sc_rise = sc_now & ~sc_prev_reg;

	////////////////////////////////////////////////////////////////////////
	// status registers
	csf_data_t pwr_reg;
	csf_data_t short_reg;
	csf_data_t latched_reg;
	csf_data_t latched_next;
	logic live_btn_reg;
	csf_data_t live_val;
	logic rd_latched;
	logic rd_btn_clr;

	// strobe qualified by one register offset
	function automatic logic hit(input logic strobe, input csf_addr_t a, input csf_addr_t off);
		return strobe && (a == off);
	endfunction

	// interrupt word widened to the bus width
	function automatic csf_data_t widen(input logic [CSF_IRQ_W-1:0] v);
		return {{(CSF_DW-CSF_IRQ_W){1'b0}}, v};
	endfunction

	assign rd_latched = hit(rd, addr, CSF_OFF_LATCHED);
	assign rd_btn_clr = hit(rd, addr, CSF_OFF_BTN_CLR);

	// (RULE2) converter power bits
	// (RULE3) line driver bits
	// (RULE4) headphone driver bits
	// (RULE5) reserved bit 0 zero
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			pwr_reg <= CSF_RST;
		end else begin
			pwr_reg <= CSF_RST;
			pwr_reg[CSF_PWR_LDAC] <= q_reg[IX_LDAC];
			pwr_reg[CSF_PWR_RDAC] <= q_reg[IX_RDAC];
			pwr_reg[CSF_PWR_MONO] <= q_reg[IX_MONO];
			pwr_reg[CSF_PWR_LLINE] <= q_reg[IX_LLINE];
			pwr_reg[CSF_PWR_RLINE] <= q_reg[IX_RLINE];
			pwr_reg[CSF_PWR_LHP] <= q_reg[IX_LHP];
			pwr_reg[CSF_PWR_RHP] <= q_reg[IX_RHP];
		end
	end

	// (RULE6) live short bits
	// (RULE7) common driver power
	// (RULE8) reserved bits zero
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			short_reg <= CSF_RST;
		end else begin
			short_reg <= CSF_RST;
			short_reg[CSF_SC_HI:CSF_SC_LO] <= sc_now;
			short_reg[CSF_SC_LCOM_PWR] <= q_reg[IX_LCOM];
			short_reg[CSF_SC_RCOM_PWR] <= q_reg[IX_RCOM];
		end
	end

	// (RULE9) latch short events
	// (RULE10) latch button and headset
	// (RULE11) latch noise-gate state
	always_comb begin
		latched_next = latched_reg;
		// (RULE15) read clears, events win
		if (rd_latched) begin
			latched_next = CSF_RST;
		end
		latched_next[CSF_SC_HI:CSF_SC_LO] = latched_next[CSF_SC_HI:CSF_SC_LO] | sc_rise;
		latched_next[CSF_FL_BTN] = latched_next[CSF_FL_BTN] | btn_rise;
		latched_next[CSF_FL_HSET] = latched_next[CSF_FL_HSET] | hset_chg;
		latched_next[CSF_FL_LNOISE] = latched_next[CSF_FL_LNOISE] | noise_now[1];
		latched_next[CSF_FL_RNOISE] = latched_next[CSF_FL_RNOISE] | noise_now[0];
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			latched_reg <= CSF_RST;
		end else begin
			latched_reg <= latched_next;
		end
	end

	// (RULE14) button bit cleared by register 14 read
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			live_btn_reg <= 1'b0;
		end else if (btn_rise) begin
			live_btn_reg <= 1'b1;
		end else if (rd_btn_clr) begin
			live_btn_reg <= 1'b0;
		end
	end

	// (RULE12) live short condition
	// (RULE13) headset present level
	always_comb begin
		live_val = CSF_RST;
		live_val[CSF_SC_HI:CSF_SC_LO] = sc_now;
		live_val[CSF_FL_BTN] = live_btn_reg;
		live_val[CSF_FL_HSET] = hset_now;
		live_val[CSF_FL_LNOISE] = noise_now[1];
		live_val[CSF_FL_RNOISE] = noise_now[0];
	end

	////////////////////////////////////////////////////////////////////////
	// interrupt status, enable and clear
	logic [CSF_IRQ_W-1:0] ist_reg;
	logic [CSF_IRQ_W-1:0] ien_reg;
	logic [CSF_IRQ_W-1:0] iev;
	logic [CSF_IRQ_W-1:0] iclr;
	logic [1:0] noise_prev_reg;
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			noise_prev_reg <= 2'h0;
		end else begin
			noise_prev_reg <= noise_now;
		end
	end
	assign iev[CSF_IRQ_SHORT] = |sc_rise;
	assign iev[CSF_IRQ_BTN] = btn_rise;
	assign iev[CSF_IRQ_HSET] = hset_chg;
	assign iev[CSF_IRQ_NOISE] = |(noise_now & ~noise_prev_reg);
	assign iclr = hit(wr, addr, CSF_OFF_IRQ_CLR) ? wdata[CSF_IRQ_W-1:0] : '0;

	// set wins over clear
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ist_reg <= '0;
		end else begin
			ist_reg <= (ist_reg & ~iclr) | iev;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ien_reg <= '0;
		end else if (hit(wr, addr, CSF_OFF_IRQ_EN)) begin
			ien_reg <= wdata[CSF_IRQ_W-1:0];
		end
	end

	assign irq = |(ist_reg & ien_reg);

	////////////////////////////////////////////////////////////////////////
	// read data, one cycle after the strobe
	// (RULE1) read-only decode
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rdata <= CSF_RST;
		end else if (rd) begin
			unique case (addr)
				CSF_OFF_PWR: rdata <= pwr_reg;
				CSF_OFF_SHORT: rdata <= short_reg;
				CSF_OFF_LATCHED: rdata <= latched_reg;
				CSF_OFF_LIVE: rdata <= live_val;
				CSF_OFF_IRQ_STAT: rdata <= widen(ist_reg);
				CSF_OFF_IRQ_EN: rdata <= widen(ien_reg);
				default: rdata <= CSF_RST;
			endcase
		end else begin
			rdata <= CSF_RST;
		end
	end
endmodule // csf_status_regs

/* File: tb/csf_status_regs_sva.sv */
// assertion checker for the codec status flag registers
module csf_status_regs_sva (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// register port
	input wire csf_pkg::csf_addr_t addr,
	input wire logic rd,
	input wire csf_pkg::csf_data_t rdata,
	input wire logic irq,
	// detectors
	input wire logic left_dac_powered,
	input wire logic [3:0] driver_short,
	input wire logic headset_present,
	input wire logic left_noise_low
);
	timeunit 1ns;
	timeprecision 1ps;
	import csf_pkg::*;
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	idle_read_zero_a: assert property (!$past(rd) |-> rdata == 8'h00)
		else $error("rdata set with no read");
	pwr_spare_zero_a: assert property (rd && addr == CSF_OFF_PWR |=> !rdata[0])
		else $error("power spare bit set");
	short_spare_zero_a: assert property (rd && addr == CSF_OFF_SHORT |=> rdata[1:0] == 2'b00)
		else $error("short spare bits set");
	ldac_power_a: assert property (left_dac_powered [*8] ##0 rd && addr == CSF_OFF_PWR |=> rdata[7])
		else $error("converter power bit low");
	hp_short_a: assert property (driver_short[3] [*8] ##0 rd && addr == CSF_OFF_SHORT |=> rdata[7])
		else $error("short bit low");
	no_headset_a: assert property (!headset_present [*8] ##0 rd && addr == CSF_OFF_LIVE |=> !rdata[2])
		else $error("headset bit high");
	noise_live_a: assert property (left_noise_low [*8] ##0 rd && addr == CSF_OFF_LIVE |=> rdata[1])
		else $error("noise bit low");
	live_short_a: assert property (!driver_short[0] [*8] ##0 rd && addr == CSF_OFF_LIVE |=> !rdata[4])
		else $error("live short bit high");
	cover property (rd && addr == CSF_OFF_LATCHED ##1 rdata != 8'h00);
	cover property (irq);
	cover property (rd && addr == 8'h10);
endmodule // csf_status_regs_sva

bind csf_status_regs csf_status_regs_sva chk (.clk(clk), .rst(rst), .addr(addr), .rd(rd), .rdata(rdata),
	.irq(irq), .left_dac_powered(left_dac_powered), .driver_short(driver_short),
	.headset_present(headset_present), .left_noise_low(left_noise_low));

/* File: tb/csf_status_regs_tb_top.sv */
// self-checking bench for the codec status flag registers
module csf_status_regs_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import csf_pkg::*;
	logic clk = 0, rst = 1, wr = 0, rd = 0, rd_q = 0, irq;
	csf_addr_t addr = 8'h00;
	csf_data_t wdata = 8'h00, rdata;
	logic [16:0] det = 17'h0;
	csf_data_t exp_q[$];
	int n_errors = 0, checked = 0, seed = 86970;
	csf_status_regs dut (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
		.left_dac_powered(det[6]), .right_dac_powered(det[5]), .mono_line_driver_powered(det[4]),
		.left_line_driver_powered(det[3]), .right_line_driver_powered(det[2]),
		.left_headphone_driver_powered(det[1]), .right_headphone_driver_powered(det[0]),
		.left_common_driver_powered(det[8]), .right_common_driver_powered(det[7]),
		.driver_short(det[12:9]), .button_press(det[16]), .headset_present(det[15]),
		.left_noise_low(det[14]), .right_noise_low(det[13]), .irq(irq));
	initial forever #10 clk = ~clk;
	////////////////////////////////////////////////////////////
	task end_of_test;
		if (n_errors == 0 && checked > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task cmp(input csf_data_t got, input csf_data_t x);
		checked++;
		if (got !== x) begin
			n_errors++;
			$display("ERROR %0t rdata %h exp %h", $time, got, x);
		end
	endtask
	task chk_irq(input logic x);
		@(negedge clk);
		checked++;
		if (irq !== x) begin
			n_errors++;
			$display("ERROR %0t irq %h exp %h", $time, irq, x);
		end
	endtask
	task rd_reg(input csf_addr_t a, input csf_data_t x);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		exp_q.push_back(x);
		@(posedge clk);
		rd <= 1'b0;
	endtask
	task wr_reg(input csf_addr_t a, input csf_data_t d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task set_det(input logic [16:0] v);
		@(posedge clk);
		det <= v;
		repeat (8) @(posedge clk);
	endtask
	// read data monitor
	always @(posedge clk) begin
		if (rd_q)
			cmp(rdata, exp_q.pop_front());
		rd_q <= rd;
	end
	////////////////////////////////////////////////////////////
	initial begin
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		for (int i = 0; i < 4; i++)
			rd_reg(csf_addr_t'(CSF_OFF_PWR + i), 8'h00);
		rd_reg(8'h10, 8'h00);
		set_det(17'h19000);
		set_det(17'h08000);
		rd_reg(CSF_OFF_LATCHED, 8'h8c);
		rd_reg(CSF_OFF_LATCHED, 8'h00);
		rd_reg(CSF_OFF_LIVE, 8'h0c);
		rd_reg(CSF_OFF_BTN_CLR, 8'h00);
		rd_reg(CSF_OFF_LIVE, 8'h04);
		wr_reg(CSF_OFF_IRQ_CLR, 8'h0f);
		wr_reg(CSF_OFF_IRQ_EN, 8'h08);
		chk_irq(1'b0);
		set_det(17'h0c000);
		rd_reg(CSF_OFF_LATCHED, 8'h02);
		rd_reg(CSF_OFF_LIVE, 8'h06);
		chk_irq(1'b1);
		rd_reg(CSF_OFF_IRQ_STAT, 8'h08);
		rd_reg(CSF_OFF_IRQ_EN, 8'h08);
		rd_reg(CSF_OFF_IRQ_CLR, 8'h00);
		wr_reg(CSF_OFF_IRQ_EN, 8'h00);
		chk_irq(1'b0);
		wr_reg(CSF_OFF_IRQ_CLR, 8'h08);
		rd_reg(CSF_OFF_IRQ_STAT, 8'h00);
		repeat (24) begin
			set_det({1'b0, 16'($random(seed))});
			wr_reg(CSF_OFF_PWR, 8'hff);
			rd_reg(CSF_OFF_PWR, {det[6:0], 1'b0});
			rd_reg(CSF_OFF_SHORT, {det[12:7], 2'b00});
			rd_reg(CSF_OFF_LIVE, {det[12:9], 1'b0, det[15:13]});
		end
		repeat (2) @(posedge clk);
		end_of_test;
	end
	// watchdog
	initial begin
		#200000;
		n_errors++;
		end_of_test;
	end
endmodule // csf_status_regs_tb_top
